// >>> ipt_pkg.sv
package ipt_pkg;
  // port base addresses
  localparam logic [15:0] PRI_CMD_BASE = 16'h01F0;
  localparam logic [15:0] PRI_CTL_BASE = 16'h03F4;
  localparam logic [15:0] SEC_CMD_BASE = 16'h0170;
  localparam logic [15:0] SEC_CTL_BASE = 16'h0374;
  // register offsets within the blocks
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_DRVHEAD = 3'h6;
  localparam logic [1:0] OFS_ALTSTAT = 2'h2;
  localparam int DRV_SEL_BIT = 4;
  // compatible timing in ns, rounded up to clock counts (mode 0 like)
  localparam int COMPAT_ACTIVE_NS = 290;
  localparam int COMPAT_RECOV_NS = 310;
  localparam int CLK_NS = 20;
  // five bits: the recovery count of 16 would wrap to 0 in four
  localparam logic [4:0] COMPAT_ACTIVE_CYC =
    5'((COMPAT_ACTIVE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] COMPAT_RECOV_CYC =
    5'((COMPAT_RECOV_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] SETUP_CYC = 5'h02;
  // least idle chip select gap between halves under compatible timing
  localparam logic [3:0] HALF_GAP_CYC = 4'h2;
  // fast timing field widths
  localparam int ISP_W = 2;
  localparam int RCT_W = 2;
  // fast field to clock offsets
  localparam logic [4:0] ISP_BASE = 5'h02;
  localparam logic [4:0] RCT_BASE = 5'h01;
endpackage

// >>> ipt_decode.sv
`timescale 1ns/1ps
// address decode of command and control blocks
module ipt_decode (
  input wire logic [17:0] addr_i,
  input wire logic decode_en_i,
  input wire logic secondary_i,
  input wire logic floppy_ctl_en_i,
  output logic cmd_hit_o,
  output logic ctl_hit_o,
  output logic [2:0] reg_ofs_o
);
  logic [15:0] cmd_base;
  logic [15:0] ctl_base;
  logic upper_zero;
  // base selection by connector role
  assign cmd_base = secondary_i ? ipt_pkg::SEC_CMD_BASE
                                : ipt_pkg::PRI_CMD_BASE;
  assign ctl_base = secondary_i ? ipt_pkg::SEC_CTL_BASE
                                : ipt_pkg::PRI_CTL_BASE;
  assign upper_zero = (addr_i[17:16] == 2'h0);
  // range match, alt status always, others need floppy enable
  always_comb begin
    cmd_hit_o = decode_en_i && upper_zero &&
                (addr_i[15:3] == cmd_base[15:3]);
    ctl_hit_o = decode_en_i && upper_zero &&
                (addr_i[15:2] == ctl_base[15:2]) &&
                ((addr_i[1:0] == ipt_pkg::OFS_ALTSTAT) ||
                 floppy_ctl_en_i);
    reg_ofs_o = addr_i[2:0];
  end
endmodule // ipt_decode

// >>> ipt_timer.sv
`timescale 1ns/1ps
// strobe phase timer: setup, active, recovery
module ipt_timer (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [4:0] active_cyc_i,
  input wire logic [4:0] recov_cyc_i,
  input wire logic ready_i,
  output logic strobe_o,
  output logic busy_o,
  output logic sample_o
);
  typedef enum logic [1:0] {IPT_T_IDLE, IPT_T_SETUP, IPT_T_ACT,
                            IPT_T_REC} ipt_tphase_t;
  ipt_tphase_t phase_r;
  logic [4:0] cnt_r;
  // phase sequencing, active phase waits for ready
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_r <= IPT_T_IDLE;
      cnt_r <= 5'h00;
    end else begin
      case (phase_r)
        IPT_T_IDLE: begin
          if (start_i) begin
            phase_r <= IPT_T_SETUP;
            cnt_r <= ipt_pkg::SETUP_CYC;
          end
        end
        IPT_T_SETUP: begin
          if (cnt_r <= 5'h01) begin
            phase_r <= IPT_T_ACT;
            cnt_r <= active_cyc_i;
          end else cnt_r <= cnt_r - 5'h01;
        end
        IPT_T_ACT: begin
          if (cnt_r <= 5'h01) begin
            if (ready_i) begin
              phase_r <= IPT_T_REC;
              cnt_r <= recov_cyc_i;
            end
          end else cnt_r <= cnt_r - 5'h01;
        end
        IPT_T_REC: begin
          if (cnt_r <= 5'h01) phase_r <= IPT_T_IDLE;
          else cnt_r <= cnt_r - 5'h01;
        end
        default: phase_r <= IPT_T_IDLE;
      endcase
    end
  end
  assign strobe_o = (phase_r == IPT_T_ACT);
  assign busy_o = (phase_r != IPT_T_IDLE) || start_i;
  assign sample_o = (phase_r == IPT_T_ACT) && (cnt_r <= 5'h01) && ready_i;
endmodule // ipt_timer

// >>> ipt_port.sv
`timescale 1ns/1ps
// Summary of operation
// - claim only when primary or secondary decode enabled
// - register access asserts its select and strobes
// - command range and control range selects
// - address bits 17 and 16 above base zero
// - primary bases 01F0h and 03F4h
// - secondary bases 0170h and 0374h
// - data register 16 bits, others 8
// - claim command range, control offset 02h only
// - control 00h 01h 03h need floppy enable
// - fast timing only on data port
// - two drives, one shared fast timing
// - per drive fast enable, else compatible
// - snoop drive select bit of drive/head
// - per drive mask forces ready asserted
// - 32-bit data access splits into two halves
// - compatible halves separated by two idle clocks
// - buffer direction shared, own output enable
// - address and selects on muxed address lines
// - connector selectable primary or secondary
module ipt_port (
  input wire logic clock_i,
  input wire logic resetn_i,
  // host I/O request
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_dword_i,
  input wire logic [17:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  output logic req_claim_o,
  output logic req_done_o,
  output logic [31:0] req_rdata_o,
  // timing and decode controls
  input wire logic primary_decode_en_i,
  input wire logic secondary_decode_en_i,
  input wire logic [ipt_pkg::ISP_W-1:0] strobe_sample_point_field_i,
  input wire logic [ipt_pkg::RCT_W-1:0] recovery_time_field_i,
  input wire logic drive0_fast_timing_enable_i,
  input wire logic drive1_fast_timing_enable_i,
  input wire logic drive0_ready_mask_i,
  input wire logic drive1_ready_mask_i,
  input wire logic dword_data_mode_i,
  input wire logic floppy_controller_en_i,
  input wire logic shared_pin_is_doe_i,
  // drive side
  input wire logic iordy_i,
  input wire logic [15:0] drive_data_lines_i,
  output logic [15:0] drive_data_lines_o,
  output logic [7:0] system_address_lines_o,
  output logic command_block_select_n_o,
  output logic control_block_select_n_o,
  output logic drive_read_n_o,
  output logic drive_write_n_o,
  output logic data_buffer_direction_o,
  output logic drive_data_output_enable_n_o,
  output logic drive_select_o
);
  typedef enum logic [2:0] {IPT_IDLE, IPT_LOW, IPT_GAP, IPT_HIGH,
                            IPT_DONE} ipt_state_t;
  ipt_state_t state_r;
  logic cmd_hit, ctl_hit, hit;
  logic [2:0] reg_ofs;
  logic decode_en;
  logic iordy_s1_r, iordy_s2_r;
  logic drive_sel_r;
  logic is_data;
  logic fast_sel;
  logic mask_sel;
  logic ready_eff;
  logic tim_start, tim_strobe, tim_busy, tim_sample;
  logic [4:0] act_cyc, rec_cyc;
  logic [3:0] gap_r;
  logic cmd_sel_r, ctl_sel_r, write_r, dword_r, data_r;
  logic [2:0] ofs_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic done_r;
  logic started_r;

  assign decode_en = primary_decode_en_i || secondary_decode_en_i;

  ipt_decode u_decode (
    .addr_i(req_addr_i),
    .decode_en_i(decode_en),
    .secondary_i(secondary_decode_en_i),
    .floppy_ctl_en_i(floppy_controller_en_i),
    .cmd_hit_o(cmd_hit),
    .ctl_hit_o(ctl_hit),
    .reg_ofs_o(reg_ofs)
  );
  assign hit = cmd_hit || ctl_hit;
  assign req_claim_o = req_i && hit && (state_r == IPT_IDLE);

  // iordy synchroniser
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      iordy_s1_r <= 1'b0;
      iordy_s2_r <= 1'b0;
    end else begin
      iordy_s1_r <= iordy_i;
      iordy_s2_r <= iordy_s1_r;
    end
  end

  // drive select snoop on drive/head writes
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) drive_sel_r <= 1'b0;
    else if (req_claim_o && cmd_hit && req_write_i &&
             reg_ofs == ipt_pkg::OFS_DRVHEAD)
      drive_sel_r <= req_wdata_i[ipt_pkg::DRV_SEL_BIT];
  end
  assign drive_select_o = drive_sel_r;

  // per drive timing choice
  assign is_data = cmd_sel_r && data_r;
  assign fast_sel = is_data && (drive_sel_r ? drive1_fast_timing_enable_i
                      : drive0_fast_timing_enable_i);
  assign mask_sel = drive_sel_r ? drive1_ready_mask_i
                                : drive0_ready_mask_i;
  assign ready_eff = mask_sel || iordy_s2_r;
  always_comb begin
    if (fast_sel) begin
      act_cyc = ipt_pkg::ISP_BASE +
                5'(strobe_sample_point_field_i);
      rec_cyc = ipt_pkg::RCT_BASE + 5'(recovery_time_field_i);
    end else begin
      act_cyc = ipt_pkg::COMPAT_ACTIVE_CYC;
      rec_cyc = ipt_pkg::COMPAT_RECOV_CYC;
    end
  end

  ipt_timer u_timer (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .start_i(tim_start),
    .active_cyc_i(act_cyc),
    .recov_cyc_i(rec_cyc),
    .ready_i(ready_eff),
    .strobe_o(tim_strobe),
    .busy_o(tim_busy),
    .sample_o(tim_sample)
  );

  // each half starts once on entry to its state
  assign tim_start = ((state_r == IPT_LOW) || (state_r == IPT_HIGH)) &&
                     !started_r;

  // transfer sequencer
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= IPT_IDLE;
      started_r <= 1'b0;
      gap_r <= 4'h0;
    end else begin
      case (state_r)
        IPT_IDLE: begin
          started_r <= 1'b0;
          if (req_claim_o) state_r <= IPT_LOW;
        end
        IPT_LOW: begin
          started_r <= 1'b1;
          if (started_r && !tim_busy) begin
            started_r <= 1'b0;
            if (dword_r && data_r && cmd_sel_r &&
                dword_data_mode_i) begin
              state_r <= fast_sel ? IPT_HIGH : IPT_GAP;
              gap_r <= ipt_pkg::HALF_GAP_CYC;
            end else state_r <= IPT_DONE;
          end
        end
        IPT_GAP: begin
          if (gap_r <= 4'h1) state_r <= IPT_HIGH;
          else gap_r <= gap_r - 4'h1;
        end
        IPT_HIGH: begin
          started_r <= 1'b1;
          if (started_r && !tim_busy) begin
            started_r <= 1'b0;
            state_r <= IPT_DONE;
          end
        end
        IPT_DONE: state_r <= IPT_IDLE;
        default: state_r <= IPT_IDLE;
      endcase
    end
  end

  // capture request
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_sel_r <= 1'b0;
      ctl_sel_r <= 1'b0;
      write_r <= 1'b0;
      dword_r <= 1'b0;
      data_r <= 1'b0;
      ofs_r <= 3'h0;
      wdata_r <= 32'h0000_0000;
    end else if (req_claim_o) begin
      cmd_sel_r <= cmd_hit;
      ctl_sel_r <= ctl_hit;
      write_r <= req_write_i;
      dword_r <= req_dword_i;
      data_r <= cmd_hit && (reg_ofs == ipt_pkg::OFS_DATA);
      ofs_r <= reg_ofs;
      wdata_r <= req_wdata_i;
    end
  end

  // read data capture, low half then high half
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) rdata_r <= 32'h0000_0000;
    else if (req_claim_o) rdata_r <= 32'h0000_0000;
    else if (tim_sample && !write_r) begin
      if (state_r == IPT_HIGH) rdata_r[31:16] <= drive_data_lines_i;
      else if (data_r) rdata_r[15:0] <= drive_data_lines_i;
      else rdata_r[7:0] <= drive_data_lines_i[7:0];
    end
  end
  assign req_rdata_o = rdata_r;

  // completion pulse after all halves
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) done_r <= 1'b0;
    else done_r <= (state_r == IPT_DONE);
  end
  assign req_done_o = done_r;

  // drive pins: selects held through the half, dropped in the gap
  always_comb begin
    command_block_select_n_o = !(cmd_sel_r &&
      ((state_r == IPT_LOW) || (state_r == IPT_HIGH)));
    control_block_select_n_o = !(ctl_sel_r &&
      ((state_r == IPT_LOW) || (state_r == IPT_HIGH)));
    drive_read_n_o = !(tim_strobe && !write_r);
    drive_write_n_o = !(tim_strobe && write_r);
    data_buffer_direction_o = write_r;
    drive_data_output_enable_n_o = !(shared_pin_is_doe_i &&
      ((state_r == IPT_LOW) || (state_r == IPT_HIGH)));
    // address and selects share the system address lines
    system_address_lines_o = {command_block_select_n_o,
                              control_block_select_n_o,
                              3'h0, ofs_r};
  end

  // write data half select
  assign drive_data_lines_o = (state_r == IPT_HIGH) ? wdata_r[31:16]
    : (data_r ? wdata_r[15:0] : {8'h00, wdata_r[7:0]});

  // checks
  sequence s_gap_idle;
    command_block_select_n_o [*2];
  endsequence
  a_gap_selects_off: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (state_r == IPT_LOW) ##1 (state_r == IPT_GAP) |-> s_gap_idle)
    else $error("selects not idle two clocks between halves");
  a_claim_needs_en: assert property (@(posedge clock_i)
    disable iff (!resetn_i) req_claim_o |-> decode_en)
    else $error("claim without decode enable");
  a_one_select: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    !(!command_block_select_n_o && !control_block_select_n_o))
    else $error("both selects active");
  a_ctl_claim_ofs: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (req_claim_o && ctl_hit && !floppy_controller_en_i) |->
    (req_addr_i[1:0] == 2'h2))
    else $error("control claim at wrong offset");
  a_upper_zero: assert property (@(posedge clock_i)
    disable iff (!resetn_i) req_claim_o |-> req_addr_i[17:16] == 2'h0)
    else $error("claim with upper address set");
  a_snoop_drive: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (req_claim_o && cmd_hit && req_write_i && reg_ofs == 3'h6) |=>
    drive_sel_r == $past(req_wdata_i[4]))
    else $error("drive select not snooped");
  a_strobe_sel: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (!drive_read_n_o || !drive_write_n_o) |->
    (!command_block_select_n_o || !control_block_select_n_o))
    else $error("strobe without select");
  a_fast_data_only: assert property (@(posedge clock_i)
    disable iff (!resetn_i) fast_sel |-> (cmd_sel_r && data_r))
    else $error("fast timing off data port");
  a_split_order: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (state_r == IPT_HIGH) |-> $past(state_r) != IPT_IDLE)
    else $error("high half without low half");
  a_done_after: assert property (@(posedge clock_i)
    disable iff (!resetn_i) (state_r == IPT_DONE) |=> req_done_o)
    else $error("done pulse missing");
endmodule // ipt_port

// >>> ipt_drive_model.sv
`timescale 1ns/1ps
// drive model: one command register file, no drive select, with ready stall
module ipt_drive_model (
  input wire logic clock_i,
  input wire logic sel_n_i,
  input wire logic [7:0] addr_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [15:0] wdata_i,
  input wire logic slow_i,
  output logic [15:0] rdata_o,
  output logic iordy_o
);
  logic [15:0] regs [8] = '{default: 16'h0000};
  logic [15:0] wlog [$];
  logic [15:0] last_r = 16'h0000;
  logic [15:0] wval_r = 16'h0000;
  logic [2:0] ofs_r = 3'h0;
  logic wa_r = 1'b0;
  logic ra_r = 1'b0;
  int low_cnt = 0;
  wire logic wa = !sel_n_i && !wr_n_i;
  wire logic ra = !sel_n_i && !rd_n_i;
  // a released bus shows the inverse of the last value
  assign rdata_o = ra ? regs[addr_i[2:0]] : ~last_r;
  // slow drive holds ready low for eight clocks of each strobe
  assign iordy_o = !slow_i || low_cnt >= 8;
  // sample mid-cycle, commit on strobe release
  always @(negedge clock_i) begin
    if (wa || ra) ofs_r <= addr_i[2:0];
    if (wa) wval_r <= addr_i[2:0] == 3'h0 ? wdata_i : {8'h00, wdata_i[7:0]};
    if (ra) last_r <= rdata_o;
    low_cnt <= (rd_n_i && wr_n_i) ? 0 : low_cnt + 1;
    if (wa_r && !wa) begin
      regs[ofs_r] <= wval_r;
      if (ofs_r == 3'h0) wlog.push_back(wval_r);
    end
    // data port streams: each read advances the word
    if (ra_r && !ra && ofs_r == 3'h0) regs[0] <= regs[0] + 16'h0001;
    wa_r <= wa;
    ra_r <= ra;
  end
endmodule // ipt_drive_model

// >>> tb_top.sv
`timescale 1ns/1ps
// bench for the host side ide port
module tb_top;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req_i = 0, req_write_i = 0, req_dword_i = 0;
  logic [17:0] req_addr_i = '0;
  logic [31:0] req_wdata_i = '0;
  logic pri_en = 1, sec_en = 0, fast0 = 0, fast1 = 0, mask1 = 0;
  logic dw_mode = 1, fdc_en = 0, slow = 0, doe = 1, mask0 = 0;
  logic [1:0] strobe_sample_point_field = 2'h0, recovery_time_field = 2'h0;
  logic claim, done_o, iordy, cmd_n, ctl_n, rd_n, wr_n, dir, oe, dsel;
  logic [31:0] rdata, rd, w;
  logic [15:0] dd_in, dd_out, seed = 16'h1451;
  logic [15:0] exp_r [8] = '{default: 16'h0000};
  logic [7:0] sa;
  logic [17:0] cb, kb;
  int n_errors = 0, n_checks = 0, gap = 0, min_gap = 0, cyc, f, c1, n;
  bit hit, done;

  ipt_port ipt_port_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .req_i(req_i), .req_write_i(req_write_i), .req_dword_i(req_dword_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_claim_o(claim), .req_done_o(done_o), .req_rdata_o(rdata),
    .primary_decode_en_i(pri_en), .secondary_decode_en_i(sec_en),
    .strobe_sample_point_field_i(strobe_sample_point_field), .recovery_time_field_i(recovery_time_field),
    .drive0_fast_timing_enable_i(fast0),
    .drive1_fast_timing_enable_i(fast1),
    .drive0_ready_mask_i(mask0), .drive1_ready_mask_i(mask1),
    .dword_data_mode_i(dw_mode), .floppy_controller_en_i(fdc_en),
    .shared_pin_is_doe_i(doe), .iordy_i(iordy),
    .drive_data_lines_i(dd_in), .drive_data_lines_o(dd_out),
    .system_address_lines_o(sa), .command_block_select_n_o(cmd_n),
    .control_block_select_n_o(ctl_n), .drive_read_n_o(rd_n),
    .drive_write_n_o(wr_n), .data_buffer_direction_o(dir),
    .drive_data_output_enable_n_o(oe), .drive_select_o(dsel));

  ipt_drive_model ipt_drive_model_i (.clock_i(clock_i), .sel_n_i(cmd_n),
    .addr_i(sa), .rd_n_i(rd_n), .wr_n_i(wr_n), .wdata_i(dd_out),
    .slow_i(slow), .rdata_o(dd_in), .iordy_o(iordy));

  // clock at 50 MHz
  initial forever #10 clock_i = ~clock_i;

  task automatic chk_data(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (e !== g) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_count(string nm, int lo, int hi, int g);
    n_checks++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("unexpected %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // one host request, held until done or refused
  task automatic xfer(bit wr, bit dw, logic [17:0] a, logic [31:0] wd,
                      bit eh);
    @(posedge clock_i);
    #1;
    req_write_i = wr;
    req_dword_i = dw;
    req_addr_i = a;
    req_wdata_i = wd;
    req_i = 1;
    #1;
    hit = claim === 1'b1;
    gap = -999;
    min_gap = 99;
    cyc = 0;
    done = 0;
    for (int i = 0; i < (hit ? 800 : 4) && !done; i++) begin
      @(posedge clock_i);
      #1;
      cyc++;
      done = done_o === 1'b1;
    end
    rd = rdata;
    req_i = 0;
    chk_data("claim", 32'(eh), 32'(hit));
    chk_data("done", 32'(eh), 32'(done));
  endtask

  // pin relations during strobes, select gaps within a transfer
  always @(posedge clock_i) begin
    if (!rd_n || !wr_n) begin
      chk_data("buffer dir", 32'(!wr_n), 32'(dir));
      chk_data("buffer oe", 32'(!doe), 32'(oe));
      chk_data("addr sel", 32'({cmd_n, ctl_n}), 32'(sa[7:6]));
    end
    if (cmd_n) gap <= gap + 1;
    else begin
      if (gap > 0 && gap < min_gap) min_gap <= gap;
      gap <= 0;
    end
  end

  initial begin
    #(20 * 20000);
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clock_i);
    #1 resetn_i = 1;
    for (int s = 0; s < 2; s++) begin
      pri_en = !s;
      sec_en = s;
      cb = {2'b00, s ? ipt_pkg::SEC_CMD_BASE : ipt_pkg::PRI_CMD_BASE};
      kb = {2'b00, s ? ipt_pkg::SEC_CTL_BASE : ipt_pkg::PRI_CTL_BASE};
      for (int o = 0; o < 8; o++) begin
        seed = lfsr(seed);
        xfer(1, 0, cb + 18'(o), {16'h0000, seed}, 1);
        exp_r[o] = o == 0 ? seed : {8'h00, seed[7:0]};
        if (o == 6) chk_data("drive sel", 32'(seed[4]), 32'(dsel));
      end
      for (int o = 0; o < 8; o++) begin
        xfer(0, 0, cb + 18'(o), 32'h0, 1);
        chk_data("read", {16'h0000, exp_r[o]},
          o ? {24'h0, rd[7:0]} : {16'h0, rd[15:0]});
        if (o == 0) exp_r[0]++;
      end
      xfer(0, 0, kb + 18'h0_0002, 32'h0, 1);
      for (int o = 0; o < 4; o++)
        if (o != 2) xfer(0, 0, kb + 18'(o), 32'h0, 0);
      xfer(0, 0, cb + 18'h0_0008, 32'h0, 0);
      xfer(0, 0, cb | 18'h2_0000, 32'h0, 0);
      xfer(0, 0, {2'b00, s ? ipt_pkg::PRI_CMD_BASE
        : ipt_pkg::SEC_CMD_BASE}, 32'h0, 0);
    end
    fdc_en = 1;
    for (int o = 0; o < 4; o++)
      if (o != 2) xfer(0, 0, kb + 18'(o), 32'h0, 1);
    sec_en = 0;
    xfer(0, 0, cb, 32'h0, 0);
    $display("test decode done");
    pri_en = 1;
    cb = {2'b00, ipt_pkg::PRI_CMD_BASE};
    xfer(1, 0, cb + 18'h0_0006, 32'h0, 1);
    xfer(0, 0, cb, 32'h0, 1);
    chk_count("compat cycles", 31, 800, cyc);
    fast0 = 1;
    xfer(0, 0, cb, 32'h0, 1);
    c1 = cyc;
    {strobe_sample_point_field, recovery_time_field} = 4'hf;
    xfer(0, 0, cb, 32'h0, 1);
    f = cyc;
    chk_count("field delta", 6, 6, f - c1);
    chk_count("fast cycles", 4, 30, f);
    doe = 0;
    xfer(0, 0, cb + 18'h0_0001, 32'h0, 1);
    chk_count("non-data", 31, 800, cyc);
    doe = 1;
    xfer(1, 0, cb + 18'h0_0006, 32'h10, 1);
    xfer(0, 0, cb, 32'h0, 1);
    chk_count("drive1 compat", 31, 800, cyc);
    fast1 = 1;
    xfer(0, 0, cb, 32'h0, 1);
    chk_count("drive1 fast", f, f, cyc);
    slow = 1;
    mask0 = 1;
    xfer(0, 0, cb, 32'h0, 1);
    chk_count("stalled", f + 1, 800, cyc);
    mask1 = 1;
    xfer(0, 0, cb, 32'h0, 1);
    chk_count("masked", f, f, cyc);
    {slow, mask1, fast0, fast1, mask0} = 5'h00;
    $display("test timing done");
    seed = lfsr(seed);
    w = {seed, ~seed};
    xfer(1, 1, cb, w, 1);
    chk_data("low half", 32'(w[15:0]),
      32'(ipt_drive_model_i.wlog[$-1]));
    chk_data("high half", 32'(w[31:16]),
      32'(ipt_drive_model_i.wlog[$]));
    chk_count("half gap", 2, 98, min_gap);
    exp_r[0] = w[31:16];
    for (int k = 0; k < 2; k++) begin
      fast1 = k;
      xfer(0, 1, cb, 32'h0, 1);
      chk_data("dword read", {exp_r[0] + 16'h0001, exp_r[0]}, rd);
      exp_r[0] = exp_r[0] + 16'h0002;
    end
    dw_mode = 0;
    n = ipt_drive_model_i.wlog.size();
    xfer(1, 1, cb, w, 1);
    chk_count("single", n + 1, n + 1, ipt_drive_model_i.wlog.size());
    $display("test dword done");
    finish_test();
  end
endmodule // tb_top
